/* File: hw/dam_decode.sv */
/*
  data address mode decoder: turns a classified instruction into a data
  address, a mode, a destination choice, a literal and a program target;
  holds the three file select pointers and serves their sfr bytes.
  assumes the core classifies opcodes into dam_kind_type, holds the bank
  select register and working register itself, and presents one instruction
  per instr_valid pulse; results appear one cycle later.
*/
`timescale 1ns/10ps
`include "dam_params.svh"

module dam_decode
#(
  parameter logic [7:0] ACCESS_SPLIT = `DAM_ACCESS_SPLIT
)
(
  input  logic                   core_clk,
  input  logic                   reset_n,
  input  logic                   ext_instr_enable,
  input  logic                   instr_valid,
  input  dam_pkg::dam_kind_type  instr_kind,
  input  logic [15:0]            instr_word,
  input  logic [15:0]            instr_word2,
  input  logic [3:0]             bank_select_register,
  input  logic [7:0]             working_reg,
  input  logic                   sfr_wr_en,
  input  logic [11:0]            sfr_wr_addr,
  input  logic [7:0]             sfr_wr_data,
  input  logic [11:0]            sfr_rd_addr,
  output logic                   out_valid_q,
  output dam_pkg::dam_mode_type  mode_q,
  output logic                   addr_valid_q,
  output logic [11:0]            data_addr_q,
  output logic [11:0]            data_addr2_q,
  output logic                   dest_file_q,
  output logic                   dest_working_q,
  output logic [7:0]             literal_q,
  output logic                   prog_target_valid_q,
  output logic [19:0]            prog_target_q,
  output logic [7:0]             sfr_rd_data_q,
  output logic                   sfr_rd_hit_q,
  output logic [11:0]            pointer0_q,
  output logic [11:0]            pointer1_q,
  output logic [11:0]            pointer2_q
);
  import dam_pkg::*;

  localparam logic [11:0] IND_BASE [3] = '{`DAM_IND_BASE0, `DAM_IND_BASE1, `DAM_IND_BASE2};

  logic [7:0]   lit8;          // low opcode byte
  logic         a_bit;         // access select
  logic         d_bit;         // destination select
  logic         is_dir;        // byte or bit oriented kind
  logic         low_half;      // byte falls below the access split
  logic [11:0]  banked_addr;   // bank joined with byte
  logic [11:0]  access_addr;   // fixed access bank location
  logic [11:0]  dir_addr;      // direct address before indirection
  logic         indexed;       // literal offset mode taken
  logic [11:0]  indexed_addr;  // pointer2 plus literal
  logic [11:0]  ptr_val [3];   // pointer values
  logic [11:0]  ptr_eff [3];   // address each pointer would reach
  logic [2:0]   hit;           // direct address names an indirect operand
  logic [2:0]   rd_hit;        // sfr read hits a pointer byte
  logic [7:0]   rd_part [3];   // per pointer read data
  dam_opr_type  opr [3];       // operand flavour per pointer
  logic         any_hit;       // indirect access taken
  logic [11:0]  ind_addr;      // address reached indirectly
  logic [11:0]  eff_addr;      // final first address
  dam_mode_type mode_d;        // resolved mode
  logic         dest_file_d;   // result to file register
  logic         dest_work_d;   // result to working register
  logic         load_ptr;      // pointer load instruction
  logic [1:0]   load_sel;      // which pointer to load
  logic [11:0]  load_val;      // constant to load

  // operand fields: the low byte is the 8-bit file address
  assign lit8  = instr_word[7:0];
  assign a_bit = instr_word[`DAM_A_BIT];
  assign d_bit = instr_word[`DAM_D_BIT];
  assign is_dir = (instr_kind == DAM_KIND_BYTE_D) || (instr_kind == DAM_KIND_BYTE_F) ||
                  (instr_kind == DAM_KIND_BYTE_W) || (instr_kind == DAM_KIND_BIT);

  // direct address: banked or forced into the access bank
  assign low_half    = lit8 < ACCESS_SPLIT;
  assign banked_addr = {bank_select_register, lit8};
  assign access_addr = low_half ? {`DAM_LOW_BANK, lit8} : {`DAM_SFR_BANK, lit8};
  assign dir_addr    = a_bit ? banked_addr : access_addr;

  // literal offset form replaces the low access half when enabled
  assign indexed      = is_dir && ext_instr_enable && !a_bit && low_half;
  assign indexed_addr = ptr_val[2] + {4'h0, lit8};

  // pointer load: pointer number and high nibble in word one, low byte in word two
  assign load_ptr = instr_valid && (instr_kind == DAM_KIND_LOAD_PTR);
  assign load_sel = instr_word[5:4];
  assign load_val = {instr_word[3:0], instr_word2[7:0]};

  // one pointer unit per file select pointer
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_ptr
      logic [11:0] diff;  // distance from this pointer's operand base
      assign diff       = dir_addr - IND_BASE[gi];
      assign hit[gi]    = is_dir && !indexed && (dir_addr >= IND_BASE[gi]) &&
                          (diff <= `DAM_IND_SPAN);
      assign opr[gi]    = dam_opr_type'(diff[2:0]);
      assign rd_hit[gi] = (sfr_rd_addr == IND_BASE[gi] + `DAM_PTR_LO_OFS) ||
                          (sfr_rd_addr == IND_BASE[gi] + `DAM_PTR_HI_OFS);
      assign rd_part[gi] = (sfr_rd_addr == IND_BASE[gi] + `DAM_PTR_LO_OFS) ? ptr_val[gi][7:0] :
                           (sfr_rd_addr == IND_BASE[gi] + `DAM_PTR_HI_OFS) ?
                           {4'h0, ptr_val[gi][11:8]} : 8'h00;
      dam_pointer
      #(
        .LO_ADDR (IND_BASE[gi] + `DAM_PTR_LO_OFS),
        .HI_ADDR (IND_BASE[gi] + `DAM_PTR_HI_OFS)
      )
      u_ptr
      (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .sfr_wr_en   (sfr_wr_en),
        .sfr_wr_addr (sfr_wr_addr),
        .sfr_wr_data (sfr_wr_data),
        .load_en     (load_ptr && (load_sel == 2'(gi))),
        .load_val    (load_val),
        .upd_en      (instr_valid && hit[gi]),
        .upd_op      (hit[gi] ? opr[gi] : DAM_OPR_PLAIN),
        .offset_w    (working_reg),
        .ptr_q       (ptr_val[gi]),
        .eff_addr    (ptr_eff[gi])
      );
    end
  endgenerate

  // indirect resolution; lowest pointer first, ranges never overlap anyway
  assign any_hit  = |hit;
  assign ind_addr = hit[0] ? ptr_eff[0] : hit[1] ? ptr_eff[1] : ptr_eff[2];
  assign eff_addr = (instr_kind == DAM_KIND_FULL_MOVE) ? instr_word[11:0] :
                    indexed ? indexed_addr :
                    any_hit ? ind_addr : dir_addr;

  // exactly one mode per instruction; a file op reaches at most three of them
  assign mode_d = (instr_kind == DAM_KIND_INHERENT)  ? DAM_MODE_INHERENT :
                  (instr_kind == DAM_KIND_LITERAL ||
                   instr_kind == DAM_KIND_CALL_JUMP ||
                   instr_kind == DAM_KIND_LOAD_PTR)  ? DAM_MODE_LITERAL :
                  indexed ? DAM_MODE_INDEXED :
                  any_hit ? DAM_MODE_INDIRECT : DAM_MODE_DIRECT;

  // destination: explicit bit, else fixed by the kind
  assign dest_file_d = (instr_kind == DAM_KIND_BYTE_D) ? d_bit :
                       (instr_kind == DAM_KIND_BYTE_F) || (instr_kind == DAM_KIND_BIT);
  assign dest_work_d = (instr_kind == DAM_KIND_BYTE_D) ? !d_bit :
                       (instr_kind == DAM_KIND_BYTE_W) ||
                       (instr_kind == DAM_KIND_LITERAL);

  // result registers: strobes every cycle, the rest only for a presented instruction
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_valid_q         <= 1'b0;
      mode_q              <= DAM_MODE_INHERENT;
      addr_valid_q        <= 1'b0;
      data_addr_q         <= 12'h000;
      data_addr2_q        <= 12'h000;
      dest_file_q         <= 1'b0;
      dest_working_q      <= 1'b0;
      literal_q           <= 8'h00;
      prog_target_valid_q <= 1'b0;
      prog_target_q       <= 20'h0_0000;
    end
    else
    begin
      out_valid_q         <= instr_valid;
      prog_target_valid_q <= instr_valid && (instr_kind == DAM_KIND_CALL_JUMP);
      if (instr_valid)
      begin
        mode_q         <= mode_d;
        addr_valid_q   <= is_dir || (instr_kind == DAM_KIND_FULL_MOVE);
        data_addr_q    <= eff_addr;
        data_addr2_q   <= instr_word2[11:0];
        dest_file_q    <= dest_file_d;
        dest_working_q <= dest_work_d;
        literal_q      <= lit8;
        prog_target_q  <= {instr_word2[11:0], instr_word[7:0]};
      end
    end
  end

  // registered sfr read of the pointer bytes
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sfr_rd_data_q <= 8'h00;
      sfr_rd_hit_q  <= 1'b0;
    end
    else
    begin
      sfr_rd_data_q <= rd_part[0] | rd_part[1] | rd_part[2];
      sfr_rd_hit_q  <= |rd_hit;
    end
  end

  assign pointer0_q = ptr_val[0];
  assign pointer1_q = ptr_val[1];
  assign pointer2_q = ptr_val[2];

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_banked;
    (instr_valid && is_dir && a_bit && !any_hit)
      |=> data_addr_q == {$past(bank_select_register), $past(instr_word[7:0])};
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");

  property p_access;
    (instr_valid && is_dir && !a_bit && !low_half && !any_hit)
      |=> data_addr_q == {4'hF, $past(instr_word[7:0])} && mode_q == DAM_MODE_DIRECT;
  endproperty
  a_access: assert property (p_access) else $error("access bank address wrong");

  property p_full;
    (instr_valid && instr_kind == DAM_KIND_FULL_MOVE)
      |=> data_addr_q == $past(instr_word[11:0]) && data_addr2_q == $past(instr_word2[11:0]);
  endproperty
  a_full: assert property (p_full) else $error("full move address wrong");

  property p_dest;
    (instr_valid && instr_kind == DAM_KIND_BYTE_D)
      |=> dest_file_q == $past(d_bit) && dest_working_q != $past(d_bit);
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");

  property p_no_index;
    (instr_valid && !ext_instr_enable) |=> mode_q != DAM_MODE_INDEXED;
  endproperty
  a_no_index: assert property (p_no_index) else $error("indexed without enable");

  property p_target;
    (instr_valid && instr_kind == DAM_KIND_CALL_JUMP) |=> prog_target_valid_q &&
      prog_target_q == {$past(instr_word2[11:0]), $past(instr_word[7:0])} ##1
      (!prog_target_valid_q || ($past(instr_valid) && $past(instr_kind) == DAM_KIND_CALL_JUMP));
  endproperty
  a_target: assert property (p_target) else $error("program target wrong");

  property p_postinc;
    (instr_valid && hit[0] && opr[0] == DAM_OPR_POSTINC && !sfr_wr_en && !load_ptr)
      |=> pointer0_q == $past(pointer0_q) + 12'h001 && data_addr_q == $past(pointer0_q);
  endproperty
  a_postinc: assert property (p_postinc) else $error("post increment wrong");

  property p_sfr_wr;
    (sfr_wr_en && sfr_wr_addr == IND_BASE[0] + `DAM_PTR_LO_OFS)
      |=> pointer0_q[7:0] == $past(sfr_wr_data);
  endproperty
  a_sfr_wr: assert property (p_sfr_wr) else $error("pointer byte write lost");

  property p_implicit;
    (instr_valid && instr_kind == DAM_KIND_BYTE_F) |=> dest_file_q && !dest_working_q;
  endproperty
  a_implicit: assert property (p_implicit) else $error("implicit destination wrong");

  property p_inherent;
    (instr_valid && instr_kind == DAM_KIND_INHERENT)
      |=> !addr_valid_q && mode_q == DAM_MODE_INHERENT;
  endproperty
  a_inherent: assert property (p_inherent) else $error("inherent took operand");

  property p_literal;
    (instr_valid && instr_kind == DAM_KIND_LITERAL)
      |=> literal_q == $past(instr_word[7:0]) && dest_working_q && mode_q == DAM_MODE_LITERAL;
  endproperty
  a_literal: assert property (p_literal) else $error("literal wrong");

  c_indirect: cover property (instr_valid && any_hit);
  c_indexed:  cover property (instr_valid && indexed);
  c_full:     cover property (instr_valid && instr_kind == DAM_KIND_FULL_MOVE);
  c_banked:   cover property (instr_valid && is_dir && a_bit);

endmodule : dam_decode

/* File: shared/dam_params.svh */
/*
  constants for the data address mode decoder: field positions, access bank
  layout, indirect operand placement and pointer register placement.
  assumes it is included by bare name from design files after the package.
*/
`ifndef DAM_PARAMS_SVH
`define DAM_PARAMS_SVH

// data address width and opcode field positions
`define DAM_ADDR_W        12
`define DAM_A_BIT         8
`define DAM_D_BIT         9
// access bank split: below goes to low ram, at or above to the sfr bank
`define DAM_ACCESS_SPLIT  8'h60
`define DAM_SFR_BANK      4'hF
`define DAM_LOW_BANK      4'h0
// base address of each pointer's five indirect operand addresses
`define DAM_IND_BASE0     12'hFE0
`define DAM_IND_BASE1     12'hFD8
`define DAM_IND_BASE2     12'hFD0
`define DAM_IND_SPAN      12'h004
// pointer low and high bytes sit just above the operand addresses
`define DAM_PTR_LO_OFS    12'h005
`define DAM_PTR_HI_OFS    12'h006

`endif

/* File: shared/dam_pkg.sv */
/*
  types for the data address mode decoder: instruction kinds handed over by
  the core's main decoder, the resolved addressing mode and indirect operations.
  assumes nothing beyond a systemverilog compiler.
*/
package dam_pkg;

  // instruction class, classified by the core's main opcode decoder
  typedef enum logic [3:0]
  {
    DAM_KIND_INHERENT,   // no operand at all
    DAM_KIND_LITERAL,    // 8-bit constant in the low byte
    DAM_KIND_BYTE_D,     // byte op with destination bit
    DAM_KIND_BYTE_F,     // byte op, result implicitly to the file register
    DAM_KIND_BYTE_W,     // byte op, result implicitly to working register
    DAM_KIND_BIT,        // bit op, acts on the file register
    DAM_KIND_FULL_MOVE,  // two complete 12-bit addresses
    DAM_KIND_CALL_JUMP,  // 20-bit program target
    DAM_KIND_LOAD_PTR    // load a 12-bit constant into a pointer
  } dam_kind_type;

  // addressing mode actually used for the data access
  typedef enum logic [2:0]
  {
    DAM_MODE_INHERENT,
    DAM_MODE_LITERAL,
    DAM_MODE_DIRECT,
    DAM_MODE_INDIRECT,
    DAM_MODE_INDEXED
  } dam_mode_type;

  // operand flavour, in order of offset from the pointer's operand base
  typedef enum logic [2:0]
  {
    DAM_OPR_PLAIN,
    DAM_OPR_POSTDEC,
    DAM_OPR_POSTINC,
    DAM_OPR_PREINC,
    DAM_OPR_PLUSW
  } dam_opr_type;

endpackage : dam_pkg

/* File: hw/dam_pointer.sv */
/*
  one file select pointer: a 12-bit register reachable as two sfr bytes,
  loadable by the pointer load instruction and updated by indirect accesses.
  assumes writes arrive synchronous to core_clk and at most one access a cycle.
*/
`timescale 1ns/10ps

module dam_pointer
#(
  parameter logic [11:0] LO_ADDR = 12'hFE5,
  parameter logic [11:0] HI_ADDR = 12'hFE6
)
(
  input  logic                  core_clk,
  input  logic                  reset_n,
  input  logic                  sfr_wr_en,
  input  logic [11:0]           sfr_wr_addr,
  input  logic [7:0]            sfr_wr_data,
  input  logic                  load_en,
  input  logic [11:0]           load_val,
  input  logic                  upd_en,
  input  dam_pkg::dam_opr_type  upd_op,
  input  logic [7:0]            offset_w,
  output logic [11:0]           ptr_q,
  output logic [11:0]           eff_addr
);
  import dam_pkg::*;

  logic [11:0] ptr_d;       // next pointer value
  logic [11:0] ptr_inc;     // pointer plus one
  logic [11:0] ptr_dec;     // pointer minus one
  logic [11:0] ptr_plusw;   // pointer plus signed working register
  logic        wr_lo;       // sfr write to low byte
  logic        wr_hi;       // sfr write to high nibble
  logic [11:0] upd_val;     // value after the indirect side effect

  assign ptr_inc   = ptr_q + 12'h001;
  assign ptr_dec   = ptr_q - 12'h001;
  assign ptr_plusw = ptr_q + {{4{offset_w[7]}}, offset_w};
  assign wr_lo     = sfr_wr_en && (sfr_wr_addr == LO_ADDR);
  assign wr_hi     = sfr_wr_en && (sfr_wr_addr == HI_ADDR);

  // the address reached: pre-increment and offset forms look ahead
  assign eff_addr = (upd_op == DAM_OPR_PREINC) ? ptr_inc :
                    (upd_op == DAM_OPR_PLUSW)  ? ptr_plusw : ptr_q;

  // side effect of the access; offset form leaves the pointer alone
  assign upd_val = (upd_op == DAM_OPR_POSTINC ||
                    upd_op == DAM_OPR_PREINC)  ? ptr_inc :
                   (upd_op == DAM_OPR_POSTDEC) ? ptr_dec : ptr_q;

  // a direct sfr write beats the automatic update: software intent wins
  assign ptr_d = wr_lo   ? {ptr_q[11:8], sfr_wr_data} :
                 wr_hi   ? {sfr_wr_data[3:0], ptr_q[7:0]} :
                 load_en ? load_val :
                 upd_en  ? upd_val : ptr_q;

  // pointer register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      ptr_q <= 12'h000;
    else
      ptr_q <= ptr_d;
  end

endmodule : dam_pointer

/* File: dv/dam_ram_model.sv */
/*
  behavioural banked data ram that stands behind the decoder's address outputs.
  assumes the decoder's result strobe is a one cycle pulse on core_clk.
*/
`timescale 1ns/10ps

module dam_ram_model
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        acc_valid,
  input  wire logic [11:0] acc_addr,
  input  wire logic        acc_write,
  input  wire logic [7:0]  wr_data,
  output logic [7:0]       rd_data,
  output logic [11:0]      last_addr_q,
  output logic [15:0]      acc_count_q
);
  logic [7:0] mem [0:4095];  // whole 12-bit space, banks and sfrs alike
  logic [7:0] stale_q;       // pattern shown while no access is made

  // an idle read bus toggles, so a stale byte can never pass for fresh data
  assign rd_data = acc_valid ? mem[acc_addr] : stale_q;

  // log every access; file-destined results land in the addressed byte
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      last_addr_q <= 12'h000;
      acc_count_q <= 16'h0000;
      stale_q     <= 8'hA5;
    end
    else
    begin
      stale_q <= ~stale_q;
      if (acc_valid)
      begin
        last_addr_q <= acc_addr;
        acc_count_q <= acc_count_q + 16'h0001;
        if (acc_write)
          mem[acc_addr] <= wr_data;
      end
    end
  end
endmodule : dam_ram_model

/* File: dv/tb_top.sv */
/*
  self-checking bench for the data address mode decoder with a ram model.
  assumes the decoder answers one cycle after each instruction or sfr access.
*/
`timescale 1ns/10ps
`include "dam_params.svh"

module tb_top;
  import dam_pkg::*;
  logic core_clk, reset_n, ext_instr_enable, instr_valid, sfr_wr_en;
  dam_kind_type instr_kind;
  logic [15:0] instr_word, instr_word2;
  logic [3:0]  bank_select_register;
  logic [7:0]  working_reg, sfr_wr_data, literal_q, sfr_rd_data_q, rd_data;
  logic [11:0] sfr_wr_addr, sfr_rd_addr, data_addr_q, data_addr2_q, last_addr_q;
  logic [11:0] pointer0_q, pointer1_q, pointer2_q;
  logic        out_valid_q, addr_valid_q, dest_file_q, dest_working_q;
  logic        prog_target_valid_q, sfr_rd_hit_q;
  logic [19:0] prog_target_q;
  logic [15:0] acc_count_q;
  dam_mode_type mode_q;
  int fails, checked, cycles;

  dam_decode #(.ACCESS_SPLIT(8'h60)) u_dut (.core_clk(core_clk), .reset_n(reset_n),
    .ext_instr_enable(ext_instr_enable), .instr_valid(instr_valid),
    .instr_kind(instr_kind), .instr_word(instr_word), .instr_word2(instr_word2),
    .bank_select_register(bank_select_register), .working_reg(working_reg),
    .sfr_wr_en(sfr_wr_en), .sfr_wr_addr(sfr_wr_addr), .sfr_wr_data(sfr_wr_data),
    .sfr_rd_addr(sfr_rd_addr), .out_valid_q(out_valid_q), .mode_q(mode_q),
    .addr_valid_q(addr_valid_q), .data_addr_q(data_addr_q), .data_addr2_q(data_addr2_q),
    .dest_file_q(dest_file_q), .dest_working_q(dest_working_q), .literal_q(literal_q),
    .prog_target_valid_q(prog_target_valid_q), .prog_target_q(prog_target_q),
    .sfr_rd_data_q(sfr_rd_data_q), .sfr_rd_hit_q(sfr_rd_hit_q),
    .pointer0_q(pointer0_q), .pointer1_q(pointer1_q), .pointer2_q(pointer2_q));

  dam_ram_model u_ram (.core_clk(core_clk), .reset_n(reset_n),
    .acc_valid(out_valid_q && addr_valid_q), .acc_addr(data_addr_q),
    .acc_write(dest_file_q), .wr_data(working_reg), .rd_data(rd_data),
    .last_addr_q(last_addr_q), .acc_count_q(acc_count_q));

  // 250 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // hang guard: the whole run needs about forty cycles
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      fails = fails + 1;
      close_out();
    end
  end

  // compare with case equality so unknowns count as mismatches
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // present one instruction at a falling edge; valid stays up for back to back use
  task automatic issue(input dam_kind_type k, input logic [15:0] w, input logic [15:0] w2);
    instr_valid = 1'b1;
    instr_kind  = k;
    instr_word  = w;
    instr_word2 = w2;
    @(negedge core_clk);
    check("out_valid", out_valid_q, 1'b1);
  endtask : issue

  task automatic idle();
    instr_valid = 1'b0;
    @(negedge core_clk);
  endtask : idle

  task automatic sfr_write(input logic [11:0] a, input logic [7:0] d);
    sfr_wr_en   = 1'b1;
    sfr_wr_addr = a;
    sfr_wr_data = d;
    @(negedge core_clk);
    sfr_wr_en = 1'b0;
    @(negedge core_clk);
  endtask : sfr_write

  // banked against access-bank direct addressing and the destination bit
  task automatic t_direct();
    bank_select_register = 4'h2;
    issue(DAM_KIND_BYTE_D, 16'h0345, 16'h0000);
    check("banked addr", data_addr_q, 12'h245);
    check("dest file", {dest_file_q, dest_working_q}, 2'b10);
    check("mode", mode_q, DAM_MODE_DIRECT);
    issue(DAM_KIND_BYTE_D, 16'h0045, 16'h0000);
    check("access low", data_addr_q, 12'h045);
    check("dest working", {dest_file_q, dest_working_q}, 2'b01);
    issue(DAM_KIND_BYTE_D, 16'h0280, 16'h0000);
    check("access sfr", data_addr_q, 12'hF80);
    idle();
    check("ram last", last_addr_q, 12'hF80);
    $display("test direct done");
  endtask : t_direct

  // implicit destinations, inherent and literal kinds, full moves, targets
  task automatic t_kinds();
    issue(DAM_KIND_BYTE_F, 16'h0112, 16'h0000);
    check("byte f", {dest_file_q, dest_working_q}, 2'b10);
    issue(DAM_KIND_BYTE_W, 16'h0112, 16'h0000);
    check("byte w", {dest_file_q, dest_working_q}, 2'b01);
    issue(DAM_KIND_BIT, 16'h0512, 16'h0000);
    check("bit", {dest_file_q, data_addr_q}, 13'h1212);
    issue(DAM_KIND_INHERENT, 16'h0003, 16'h0000);
    check("inherent", {mode_q, dest_file_q, dest_working_q}, {DAM_MODE_INHERENT, 2'b00});
    issue(DAM_KIND_LITERAL, 16'h0E7F, 16'h0000);
    check("literal", {mode_q, literal_q, dest_working_q}, {DAM_MODE_LITERAL, 9'h0FF});
    check("no target", prog_target_valid_q, 1'b0);
    bank_select_register = 4'h5;
    issue(DAM_KIND_FULL_MOVE, 16'h0ABC, 16'h0123);
    check("move src", data_addr_q, 12'hABC);
    check("move dst", data_addr2_q, 12'h123);
    issue(DAM_KIND_CALL_JUMP, 16'h00CD, 16'h0F12);
    check("target", {prog_target_valid_q, prog_target_q}, 21'h1F_12CD);
    check("target mode", mode_q, DAM_MODE_LITERAL);
    idle();
    check("target pulse", prog_target_valid_q, 1'b0);
    $display("test kinds done");
  endtask : t_kinds

  // pointer bytes through the sfr path and the pointer load instruction
  task automatic t_pointer_sfr();
    sfr_write(`DAM_IND_BASE0 + `DAM_PTR_LO_OFS, 8'h00);
    sfr_write(`DAM_IND_BASE0 + `DAM_PTR_HI_OFS, 8'h01);
    check("ptr0", pointer0_q, 12'h100);
    sfr_rd_addr = `DAM_IND_BASE0 + `DAM_PTR_HI_OFS;
    @(negedge core_clk);
    check("ptr0 read", {sfr_rd_hit_q, sfr_rd_data_q}, 9'h101);
    sfr_rd_addr = 12'h123;
    @(negedge core_clk);
    check("non ptr read", sfr_rd_hit_q, 1'b0);
    issue(DAM_KIND_LOAD_PTR, 16'h0017, 16'h0089);
    idle();
    check("ptr1 load", pointer1_q, 12'h789);
    $display("test pointer sfr done");
  endtask : t_pointer_sfr

  // every indirect operand flavour back to back on pointer0 at 0x100
  task automatic t_indirect();
    working_reg = 8'hFE;
    issue(DAM_KIND_BYTE_D, 16'h00E2, 16'h0000);
    check("postinc", {mode_q, data_addr_q}, {DAM_MODE_INDIRECT, 12'h100});
    check("postinc ptr", pointer0_q, 12'h101);
    issue(DAM_KIND_BYTE_D, 16'h00E1, 16'h0000);
    check("postdec", {data_addr_q, pointer0_q}, 24'h101_100);
    issue(DAM_KIND_BYTE_D, 16'h00E3, 16'h0000);
    check("preinc", {data_addr_q, pointer0_q}, 24'h101_101);
    issue(DAM_KIND_BYTE_D, 16'h00E4, 16'h0000);
    check("plus w", {data_addr_q, pointer0_q}, 24'h0FF_101);
    issue(DAM_KIND_BYTE_D, 16'h00E0, 16'h0000);
    check("plain", {data_addr_q, pointer0_q}, 24'h101_101);
    idle();
    $display("test indirect done");
  endtask : t_indirect

  // literal offset only while the extended set is enabled
  task automatic t_indexed();
    sfr_write(`DAM_IND_BASE2 + `DAM_PTR_HI_OFS, 8'h02);
    check("ptr2", pointer2_q, 12'h200);
    ext_instr_enable = 1'b1;
    issue(DAM_KIND_BYTE_D, 16'h0010, 16'h0000);
    check("indexed", {mode_q, data_addr_q}, {DAM_MODE_INDEXED, 12'h210});
    issue(DAM_KIND_BYTE_D, 16'h0160, 16'h0000);
    check("banked kept", {mode_q, data_addr_q}, {DAM_MODE_DIRECT, 12'h560});
    ext_instr_enable = 1'b0;
    issue(DAM_KIND_BYTE_D, 16'h0010, 16'h0000);
    check("no indexed", {mode_q, data_addr_q}, {DAM_MODE_DIRECT, 12'h010});
    idle();
    check("ram count", acc_count_q, 16'h000F);
    $display("test indexed done");
  endtask : t_indexed

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // reset for five cycles, then run every scenario
  initial
  begin
    fails = 0;
    checked = 0;
    cycles = 0;
    reset_n = 1'b0;
    ext_instr_enable = 1'b0;
    instr_valid = 1'b0;
    instr_kind = DAM_KIND_INHERENT;
    instr_word = 16'h0000;
    instr_word2 = 16'h0000;
    bank_select_register = 4'h0;
    working_reg = 8'h00;
    sfr_wr_en = 1'b0;
    sfr_wr_addr = 12'h000;
    sfr_wr_data = 8'h00;
    sfr_rd_addr = 12'h000;
    repeat (5) @(negedge core_clk);
    check("reset mode", {mode_q, pointer0_q}, {DAM_MODE_INHERENT, 12'h000});
    reset_n = 1'b1;
    @(negedge core_clk);
    t_direct();
    t_kinds();
    t_pointer_sfr();
    t_indirect();
    t_indexed();
    close_out();
  end
endmodule : tb_top
